// File: rtl/sfc_front_end.sv
// Serial command front end of an SPI NOR flash: frames, decodes and serialises.
// Assumes SCK runs below a quarter of CORE_CLK; all pins arrive asynchronously.
// Operation
// - Sample on SCK rise, drive on fall.
// - Either SCK idle level works alike.
// - Every byte travels most significant bit first.
// - Chip select release ends the operation.
// - Unknown opcode: ignore until reselect.
// - Early release: do nothing, return idle.
// - 24-bit address, top four bits dropped.
// - Reads 0Bh with dummy, 03h without.
// - Program 02h, address, one to 256 bytes; the code also accepts more than 256.
// - Block erases addressed, chip erase not.
// - Protect, unprotect, protection read take addresses.
// - ID read 9Fh returns up to four.
// - Power-down B9h and resume ABh, bare.
`timescale 1ns/1ps
module sfc_front_end (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic SPI_CS_N,
    input wire logic SPI_SCK,
    input wire logic SPI_SI,
    output logic SPI_SO,
    output logic SPI_SO_OE,
    output sfc_pkg::sfc_cmd_t CMD,
    output logic CMD_START,
    output logic CMD_DONE,
    output logic CMD_OK,
    output logic WR_VALID,
    output logic [7:0] WR_DATA,
    input wire logic RD_VALID,
    output logic RD_READY,
    input wire logic [7:0] RD_DATA
);
    import sfc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPCODE = 3'b001,
        ST_ADDR = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA = 3'b100,
        ST_IGNORE = 3'b101
    } sfc_state_t;

    sfc_state_t state_q;
    logic cs_s1_q, cs_s2_q, cs_p_q;
    logic sck_s1_q, sck_s2_q, sck_p_q;
    logic si_s1_q, si_s2_q;
    logic rise, fall, cs_rise;
    logic [7:0] sh_q;
    logic [7:0] byte_in;
    logic [2:0] bit_cnt_q;
    logic [1:0] abyte_q;
    logic [8:0] data_cnt_q;
    logic [23:0] addr_q;
    sfc_dec_t dec_q;
    sfc_dec_t dec_now;
    logic [7:0] so_sh_q;
    logic fifo_valid, fifo_pop;
    logic [7:0] fifo_data;
    logic load_byte;
    logic [7:0] next_out;

    // Two-stage synchronisers, then one more stage for edge detection.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_p_q <= 1'b1;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_p_q <= 1'b0;
            si_s1_q <= 1'b0;
            si_s2_q <= 1'b0;
        end else begin
            cs_s1_q <= SPI_CS_N;
            cs_s2_q <= cs_s1_q;
            cs_p_q <= cs_s2_q;
            sck_s1_q <= SPI_SCK;
            sck_s2_q <= sck_s1_q;
            sck_p_q <= sck_s2_q;
            si_s1_q <= SPI_SI;
            si_s2_q <= si_s1_q;
        end
    end

    // Edges count only while selected, so the idle SCK level never looks like a bit.
    assign rise = !cs_s2_q && sck_s2_q && !sck_p_q;
    assign fall = !cs_s2_q && !sck_s2_q && sck_p_q;
    assign cs_rise = cs_s2_q && !cs_p_q;
    assign byte_in = {sh_q[6:0], si_s2_q};
    assign dec_now = sfc_decode(byte_in);

    // Input shifter and bit counter; a new frame always starts on a byte boundary.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sh_q <= 8'h00;
            bit_cnt_q <= 3'h0;
        end else if (cs_s2_q) begin
            bit_cnt_q <= 3'h0;
        end else if (rise) begin
            sh_q <= byte_in;
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // Frame sequencer: opcode, address, dummy, then the data phase.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            dec_q <= '0;
            abyte_q <= 2'h0;
        end else if (cs_s2_q) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_q <= ST_OPCODE;
                    abyte_q <= 2'h0;
                end
                ST_OPCODE: begin
                    if (rise && bit_cnt_q == BIT_LAST) begin
                        dec_q <= dec_now;
                        if (!dec_now.known) begin
                            state_q <= ST_IGNORE;
                        end else if (dec_now.has_addr) begin
                            state_q <= ST_ADDR;
                        end else begin
                            state_q <= ST_DATA;
                        end
                    end
                end
                ST_ADDR: begin
                    if (rise && bit_cnt_q == BIT_LAST) begin
                        abyte_q <= abyte_q + 2'h1;
                        if (abyte_q == ADDR_LAST_BYTE) begin
                            state_q <= dec_q.has_dummy ? ST_DUMMY : ST_DATA;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (rise && bit_cnt_q == BIT_LAST) begin
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    state_q <= ST_DATA;
                end
                ST_IGNORE: begin
                    state_q <= ST_IGNORE;
                end
            endcase
        end
    end

    // Address capture; the upper nibble is kept here but never passed on.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            addr_q <= 24'h000000;
        end else if (state_q == ST_ADDR && rise && bit_cnt_q == BIT_LAST) begin
            addr_q <= {addr_q[15:0], byte_in};
        end
    end

    // Whole data bytes seen in the data phase, saturating.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            data_cnt_q <= 9'h000;
        end else if (state_q == ST_IDLE) begin
            data_cnt_q <= 9'h000;
        end else if (state_q == ST_DATA && rise && bit_cnt_q == BIT_LAST
                     && data_cnt_q != DATA_CNT_MAX) begin
            data_cnt_q <= data_cnt_q + 9'h001;
        end
    end

    // Command word and start pulse when the header is complete.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CMD <= '0;
            CMD_START <= 1'b0;
        end else begin
            CMD_START <= 1'b0;
            if (state_q == ST_OPCODE && rise && bit_cnt_q == BIT_LAST) begin
                CMD.opcode <= byte_in;
            end
            if (state_q != ST_DATA && !cs_s2_q && rise && bit_cnt_q == BIT_LAST
                && (state_q == ST_DUMMY
                    || (state_q == ST_ADDR && abyte_q == ADDR_LAST_BYTE && !dec_q.has_dummy)
                    || (state_q == ST_OPCODE && dec_now.known && !dec_now.has_addr))) begin
                CMD_START <= 1'b1;
            end
            if (state_q == ST_ADDR && rise && bit_cnt_q == BIT_LAST
                && abyte_q == ADDR_LAST_BYTE) begin
                CMD.addr <= {addr_q[11:0], byte_in};
                CMD.sector <= addr_q[SECTOR_LSB-8 +: 4];
                CMD.block <= addr_q[BLOCK_LSB-8 +: 4];
                CMD.page <= addr_q[PAGE_LSB-8 +: 8];
            end
        end
    end

    // End of frame: report whether the frame was complete and byte aligned.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CMD_DONE <= 1'b0;
            CMD_OK <= 1'b0;
        end else begin
            CMD_DONE <= cs_rise && state_q != ST_IDLE;
            CMD_OK <= cs_rise && state_q == ST_DATA && bit_cnt_q == 3'h0
                      && (!dec_q.need_data || data_cnt_q != 9'h000)
                      && (!dec_q.exact_one || data_cnt_q == 9'h001);
        end
    end

    // Incoming data bytes of program and status write.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            WR_VALID <= 1'b0;
            WR_DATA <= 8'h00;
        end else begin
            WR_VALID <= state_q == ST_DATA && dec_q.dir == DIR_IN && rise
                        && bit_cnt_q == BIT_LAST;
            if (state_q == ST_DATA && rise && bit_cnt_q == BIT_LAST) begin
                WR_DATA <= byte_in;
            end
        end
    end

    // A new output byte starts on the first falling edge after a byte boundary.
    // An identification read stops taking bytes after the fourth, then sends fill.
    assign load_byte = fall && state_q == ST_DATA && dec_q.dir == DIR_OUT && bit_cnt_q == 3'h0;
    assign fifo_pop = load_byte
                      && !(CMD.opcode == OP_READ_ID && data_cnt_q >= ID_MAX_BYTES);
    assign next_out = fifo_valid ? fifo_data : SO_FILL;

    // Output serialiser, shifting only on falling SCK edges.
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            SPI_SO <= 1'b1;
            so_sh_q <= 8'hff;
            SPI_SO_OE <= 1'b0;
        end else begin
            SPI_SO_OE <= !cs_s2_q && state_q == ST_DATA && dec_q.dir == DIR_OUT;
            if (load_byte) begin
                SPI_SO <= fifo_pop ? next_out[7] : 1'b1;
                so_sh_q <= fifo_pop ? {next_out[6:0], 1'b1} : 8'hff;
            end else if (fall) begin
                SPI_SO <= so_sh_q[7];
                so_sh_q <= {so_sh_q[6:0], 1'b1};
            end
        end
    end

    // Read data from the core, flushed whenever chip select is high.
    sfc_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rd_fifo (
        .clk(CORE_CLK),
        .rst_n(RESETN),
        .flush(cs_s2_q),
        .in_valid(RD_VALID),
        .in_ready(RD_READY),
        .in_data(RD_DATA),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // Checks on the frame sequencer and the serial pins.
    a_sample_on_rise: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        rise && !cs_s2_q |=> sh_q[0] == $past(si_s2_q))
        else $error("Input bit not taken on SCK rise.");
    a_so_on_fall: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        $changed(SPI_SO) |-> $past(fall))
        else $error("Serial output changed without a falling SCK edge.");
    a_idle_no_edge: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        cs_s2_q |-> !rise && !fall)
        else $error("SCK edge seen while deselected.");
    a_start_after_hdr: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        CMD_START |-> state_q == ST_DATA && $past(state_q) != ST_DATA)
        else $error("Start pulse without completing the header.");
    a_release_ends: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        cs_rise |=> state_q == ST_IDLE && !SPI_SO_OE)
        else $error("Frame not ended by chip select release.");
    a_ignore_holds: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        state_q == ST_IGNORE && !cs_s2_q |=> state_q == ST_IGNORE && !WR_VALID && !CMD_START)
        else $error("Unknown opcode did not keep the frame ignored.");
    a_early_release: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        cs_rise && state_q != ST_DATA && state_q != ST_IDLE |=> CMD_DONE && !CMD_OK)
        else $error("Truncated frame reported as good.");
    a_addr_masked: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        CMD_START && dec_q.has_addr |-> CMD.addr == addr_q[ARRAY_ADDR_W-1:0])
        else $error("Array address does not match the low 20 address bits.");
    a_prog_needs_data: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        CMD_OK && CMD.opcode == OP_PROGRAM |-> $past(data_cnt_q) != 9'h000)
        else $error("Program accepted without a data byte.");
    a_id_limit: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
        load_byte && CMD.opcode == OP_READ_ID && data_cnt_q >= ID_MAX_BYTES |-> !fifo_pop)
        else $error("More than four identification bytes taken.");
endmodule // sfc_front_end

// File: rtl/sfc_pkg.sv
// Constants, opcode table and carrier types for the serial flash command front end.
// Assumes a single core clock domain; all SPI pins are resynchronised by the user module.
package sfc_pkg;

    // Opcodes that the front end recognises.
    localparam logic [7:0] OP_READ_FAST = 8'h0b;
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
    localparam logic [7:0] OP_WRITE_EN = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS = 8'h04;
    localparam logic [7:0] OP_PROTECT = 8'h36;
    localparam logic [7:0] OP_UNPROTECT = 8'h39;
    localparam logic [7:0] OP_READ_PROT = 8'h3c;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_READ_ID = 8'h9f;
    localparam logic [7:0] OP_POWER_DOWN = 8'hb9;
    localparam logic [7:0] OP_POWER_UP = 8'hab;

    // Framing and array geometry.
    localparam int BYTE_W = 8;
    localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int ARRAY_ADDR_W = 20;
    localparam int SECTOR_LSB = 16;
    localparam int BLOCK_LSB = 12;
    localparam int PAGE_LSB = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [7:0] SO_FILL = 8'hff;
    localparam logic [8:0] ID_MAX_BYTES = 9'h004;
    localparam logic [8:0] DATA_CNT_MAX = 9'h1ff;

    // Direction of the data phase.
    typedef enum logic [1:0] {
        DIR_NONE = 2'b00,
        DIR_IN = 2'b01,
        DIR_OUT = 2'b10
    } sfc_dir_t;

    // Decoded shape of one opcode.
    typedef struct packed {
        logic known;
        logic has_addr;
        logic has_dummy;
        sfc_dir_t dir;
        logic need_data;
        logic exact_one;
    } sfc_dec_t;

    // Command handed to the core: opcode, masked address and its array coordinates.
    typedef struct packed {
        logic [7:0] opcode;
        logic [ARRAY_ADDR_W-1:0] addr;
        logic [3:0] sector;
        logic [3:0] block;
        logic [7:0] page;
    } sfc_cmd_t;

    // Classifies an opcode by its address, dummy and data phases.
    function automatic sfc_dec_t sfc_decode(input logic [7:0] op);
        sfc_dec_t d;
        d = '{known: 1'b1, has_addr: 1'b0, has_dummy: 1'b0, dir: DIR_NONE,
              need_data: 1'b0, exact_one: 1'b0};
        unique case (op)
            OP_READ_FAST: begin
                d.has_addr = 1'b1;
                d.has_dummy = 1'b1;
                d.dir = DIR_OUT;
            end
            OP_READ_SLOW, OP_READ_PROT: begin
                d.has_addr = 1'b1;
                d.dir = DIR_OUT;
            end
            OP_PROGRAM: begin
                d.has_addr = 1'b1;
                d.dir = DIR_IN;
                d.need_data = 1'b1;
            end
            OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_PROTECT, OP_UNPROTECT: begin
                d.has_addr = 1'b1;
            end
            OP_READ_STATUS, OP_READ_ID: begin
                d.dir = DIR_OUT;
            end
            OP_WRITE_STATUS: begin
                d.dir = DIR_IN;
                d.need_data = 1'b1;
                d.exact_one = 1'b1;
            end
            OP_CHIP_ERASE_A, OP_CHIP_ERASE_B, OP_WRITE_EN, OP_WRITE_DIS,
            OP_POWER_DOWN, OP_POWER_UP: begin
                d.known = 1'b1;
            end
            default: begin
                d.known = 1'b0;
            end
        endcase
        return d;
    endfunction

endpackage

// File: rtl/sfc_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes one clock; the fill side ready is registered so it can leave the chip directly.
`timescale 1ns/1ps
module sfc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Handshakes on both sides.
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];

    // Storage write.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers, fill level and registered ready.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end else if (flush) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            in_ready <= ((cnt_q + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH));
        end
    end
endmodule // sfc_fifo

// File: tb/sfc_spi_host.sv
// Behavioural SPI master that drives the flash front end in mode 0 or mode 3.
// Assumes the bench calls its tasks in turn; pins change only at falling core edges.
`timescale 1ns/1ps
module sfc_spi_host #(
    parameter int HALF = 6
) (
    input wire logic clk,
    input wire logic so,
    output logic cs_n,
    output logic sck,
    output logic si
);
    logic idle_hi = 1'b0;

    // Pins start idle: deselected, clock low.
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end

    // Sets the idle clock level of the mode, then selects the device.
    task automatic open_frame(input logic mode3);
        @(negedge clk);
        idle_hi = mode3;
        sck = mode3;
        repeat (HALF) @(negedge clk);
        cs_n = 1'b0;
        repeat (HALF) @(negedge clk);
    endtask

    // Shifts n bits out on SI and gathers SO just before each rising clock.
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            sck = 1'b0;
            si = tx[i];
            repeat (HALF) @(negedge clk);
            rx[i] = so;
            sck = 1'b1;
            repeat (HALF) @(negedge clk);
        end
    endtask

    // Returns the clock to idle, deselects and lets SI wander off its last value.
    task automatic close_frame();
        if (!idle_hi) sck = 1'b0;
        repeat (HALF) @(negedge clk);
        cs_n = 1'b1;
        si = ~si;
        repeat (2 * HALF) @(negedge clk);
    endtask
endmodule // sfc_spi_host

// File: tb/testbench.sv
// Self-checking bench for the serial flash command front end.
// Assumes the host model in sfc_spi_host.sv; the bench itself plays the core side.
`timescale 1ns/1ps
module testbench;
    import sfc_pkg::*;
    typedef struct packed {logic chk; logic [7:0] op; logic [19:0] a;} sfc_exp_t;
    logic CORE_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic SPI_CS_N, SPI_SCK, SPI_SI, SPI_SO, SPI_SO_OE;
    sfc_cmd_t CMD;
    logic CMD_START, CMD_DONE, CMD_OK, WR_VALID, RD_READY;
    logic RD_VALID = 1'b0;
    logic [7:0] WR_DATA, RD_DATA;
    logic xfer = 1'b0;
    logic feed_en = 1'b0;
    logic full_seen = 1'b0;
    logic [7:0] feed[$];
    sfc_exp_t exp_start[$];
    sfc_exp_t e;
    logic exp_done[$];
    logic [7:0] exp_wr[$];
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [7:0] ops[18] = '{8'h0b, 8'h03, 8'h02, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h06,
                            8'h04, 8'h36, 8'h39, 8'h3c, 8'h05, 8'h01, 8'h9f, 8'hb9, 8'hab};

    sfc_front_end sfc_front_end_inst (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
        .SPI_CS_N(SPI_CS_N), .SPI_SCK(SPI_SCK), .SPI_SI(SPI_SI), .SPI_SO(SPI_SO),
        .SPI_SO_OE(SPI_SO_OE), .CMD(CMD), .CMD_START(CMD_START), .CMD_DONE(CMD_DONE),
        .CMD_OK(CMD_OK), .WR_VALID(WR_VALID), .WR_DATA(WR_DATA), .RD_VALID(RD_VALID),
        .RD_READY(RD_READY), .RD_DATA(RD_DATA));

    // A released SO line shows the inverse of its last value, so late enables show up.
    sfc_spi_host #(.HALF(6)) sfc_spi_host_inst (.clk(CORE_CLK),
        .so(SPI_SO_OE ? SPI_SO : ~SPI_SO),
        .cs_n(SPI_CS_N), .sck(SPI_SCK), .si(SPI_SI));

    // Core clock of 100 ns period.
    always #50 CORE_CLK = ~CORE_CLK;

    // Cuts a hang short well beyond the length of the sequence.
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            close_out();
        end
    end

    // Counts one comparison and reports a mismatch at once.
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic close_out();
        if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic is_addr(input logic [7:0] op);
        return op inside {8'h0b, 8'h03, 8'h02, 8'h20, 8'h52, 8'hd8, 8'h36, 8'h39, 8'h3c};
    endfunction

    function automatic logic is_out(input logic [7:0] op);
        return op inside {8'h0b, 8'h03, 8'h3c, 8'h05, 8'h9f};
    endfunction

    // Core side: pushes read bytes and matches each output pulse with the oldest note.
    always @(negedge CORE_CLK) begin
        if (xfer) void'(feed.pop_front());
        if (CMD_START === 1'b1) begin
            feed_en = 1'b1;
            if (exp_start.size() == 0) chk("cmd_start_spare", 1'b0, 1'b1);
            else begin
                e = exp_start.pop_front();
                chk("opcode", e.op, CMD.opcode);
                if (e.chk) begin
                    chk("addr", e.a, CMD.addr);
                    chk("sector", e.a[19:16], CMD.sector);
                    chk("block", e.a[15:12], CMD.block);
                    chk("page", e.a[15:8], CMD.page);
                end
            end
        end
        if (CMD_DONE === 1'b1) begin
            feed_en = 1'b0;
            if (exp_done.size() == 0) chk("cmd_done_spare", 1'b0, 1'b1);
            else chk("cmd_ok", exp_done.pop_front(), CMD_OK);
        end
        if (WR_VALID === 1'b1) begin
            if (exp_wr.size() == 0) chk("wr_spare", 1'b0, 1'b1);
            else chk("wr_data", exp_wr.pop_front(), WR_DATA);
        end
        if (RD_VALID && RD_READY === 1'b0) full_seen = 1'b1;
        RD_VALID = feed_en && feed.size() > 0;
        RD_DATA = (feed.size() > 0) ? feed[0] : 8'($urandom);
        xfer = RD_VALID && RD_READY === 1'b1;
    end

    // One frame: opcode, naddr address bytes, dummy for fast read, nd data bytes, tail bits.
    task automatic frame(input logic [7:0] op, input int naddr, input int nd, input int tail,
                         input logic ok, input logic mode3);
        logic [23:0] a;
        logic [7:0] rx;
        logic [7:0] want;
        logic [7:0] d[$];
        logic known;
        a = 24'($urandom);
        known = op inside {ops};
        for (int i = 0; i < nd; i++) d.push_back(8'($urandom));
        feed.delete();
        if (is_out(op)) feed = d;
        if (known && naddr == (is_addr(op) ? 3 : 0)) exp_start.push_back({is_addr(op), op, a[19:0]});
        exp_done.push_back(ok);
        sfc_spi_host_inst.open_frame(mode3);
        sfc_spi_host_inst.shift(op, 8, rx);
        for (int i = 2; i >= 3 - naddr; i--) sfc_spi_host_inst.shift(a[8*i +: 8], 8, rx);
        if (op == 8'h0b && naddr == 3) sfc_spi_host_inst.shift(8'($urandom), 8, rx);
        foreach (d[i]) begin
            if (known && (op == 8'h02 || op == 8'h01)) exp_wr.push_back(d[i]);
            sfc_spi_host_inst.shift(d[i], 8, rx);
            want = (op == 8'h9f && i >= ID_MAX_BYTES) ? SO_FILL : d[i];
            if (is_out(op)) chk("rd_byte", want, rx);
            if (is_out(op)) chk("so_oe_data", 1'b1, SPI_SO_OE);
        end
        if (tail > 0) sfc_spi_host_inst.shift(8'($urandom), tail, rx);
        sfc_spi_host_inst.close_frame();
        chk("so_oe_idle", 1'b0, SPI_SO_OE);
    endtask

    // Main sequence: every opcode in alternating modes, then refusals and a long read.
    initial begin
        logic [7:0] op;
        void'($urandom(32'hf52bb1e9));
        repeat (3) @(negedge CORE_CLK);
        RESETN = 1'b1;
        repeat (4) @(negedge CORE_CLK);
        foreach (ops[i]) begin
            op = ops[i];
            frame(op, is_addr(op) ? 3 : 0, is_out(op) ? 2 : ((op == 8'h02 || op == 8'h01) ? 1 : 0),
                  0, 1'b1, i[0]);
        end
        frame(8'h77, 3, 2, 0, 1'b0, 1'b0);
        frame(8'h02, 2, 0, 0, 1'b0, 1'b1);
        frame(8'h20, 3, 0, 4, 1'b0, 1'b0);
        frame(8'h01, 0, 2, 0, 1'b0, 1'b1);
        frame(8'h02, 3, 0, 0, 1'b0, 1'b0);
        frame(8'h02, 3, 3, 0, 1'b1, 1'b1);
        frame(8'h0b, 3, 20, 0, 1'b1, 1'b0);
        frame(8'h9f, 0, 6, 0, 1'b1, 1'b1);
        chk("fifo_full_seen", 1'b1, full_seen);
        chk("notes_left", 32'h0, exp_start.size() + exp_done.size() + exp_wr.size());
        close_out();
    end
endmodule // testbench
